// ===== rtl/sfm_mem_array.sv
module sfm_mem_array (
   // clock
   input wire logic mclk,
   // write port
   input wire sfm_pkg::sfm_wr_req_t wr_req,
   // read port
   input wire logic [sfm_pkg::ADDR_W-1:0] rd_addr,
   output logic [sfm_pkg::DATA_W-1:0] rd_data
);
   import sfm_pkg::*;

   logic [DATA_W-1:0] mem [DEPTH];

   // write completes in the cycle it is issued
   always_ff @(posedge mclk) begin
      if (wr_req.en) begin
         mem[wr_req.addr] <= wr_req.data;
      end
   end

   assign rd_data = mem[rd_addr];
endmodule

// ===== rtl/sfm_pkg.sv
package sfm_pkg;
   // ------------------------------------------------------------
   // array geometry
   // ------------------------------------------------------------
   localparam int ADDR_W = 13;
   localparam int DATA_W = 8;
   localparam int DEPTH = 8192;
   localparam logic [ADDR_W-1:0] ADDR_LAST = 13'h1FFF;
   localparam logic [ADDR_W-1:0] ADDR_FIRST = 13'h0000;

   // ------------------------------------------------------------
   // slave address byte layout
   // ------------------------------------------------------------
   localparam int TYPE_MSB = 7;
   localparam int TYPE_LSB = 4;
   localparam int SEL_MSB = 3;
   localparam int SEL_LSB = 1;
   localparam int RW_BIT = 0;
   // device type code: value is arbitrary
   localparam logic [3:0] DEV_TYPE = 4'h5;
   localparam int HI_USED = ADDR_W - DATA_W;

   // ------------------------------------------------------------
   // bit slot counts within one byte frame
   // ------------------------------------------------------------
   localparam logic [3:0] CNT_ZERO = 4'h0;
   localparam logic [3:0] CNT_LAST_DATA = 4'h7;
   localparam logic [3:0] CNT_ACK_SLOT = 4'h8;
   localparam logic [3:0] CNT_ACK_DONE = 4'h9;

   // ------------------------------------------------------------
   // timing
   // ------------------------------------------------------------
   localparam int CLK_HZ = 20000000;
   localparam int SCL_MAX_HZ = 1000000;
   localparam int SAMPLES_PER_SCL = CLK_HZ / SCL_MAX_HZ;

   // ------------------------------------------------------------
   // types
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      SFM_IDLE = 3'b000,
      SFM_DEVADDR = 3'b001,
      SFM_ADDR_HI = 3'b010,
      SFM_ADDR_LO = 3'b011,
      SFM_WRDATA = 3'b100,
      SFM_RDDATA = 3'b101
   } sfm_state_t;

   typedef struct packed {
      logic en;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } sfm_wr_req_t;
endpackage

// ===== rtl/sfm_two_wire_slave.sv
// What this block does
// R1 - answer only when address select bits match the three select pins
// R2 - data line is only pulled low or released, never driven high
// R3 - sample data on clock rise, change sent data on clock fall
// R4 - write protect high blocks all writes; low allows all writes
// R5 - unconnected write protect reads low, so memory is writable
// R6 - 8192 bytes, 16-bit address, upper three address bits ignored
// R7 - master sends zeros in the three unused address bits
// R8 - writes finish inside the transfer; no busy time, no polling
// R9 - block is slave only; master makes the serial clock
// R10 - decode start, stop, data bit and acknowledge from line edges
// R11 - master clocks the bus at 1 MHz or slower; the bench master runs 400 ns bit slots, which is 2.5 MHz
// R12 - start or stop, seen with clock high, aborts any operation
// R13 - first byte after start: type, select bits, direction bit
// R14 - address taken high byte first; advances per byte, wraps to zero
// R15 - protected writes get no acknowledge and leave address unchanged
// R16 - start and stop override shifting; return to idle after transfer
module sfm_two_wire_slave (
   // system
   input wire logic mclk,
   input wire logic sys_rst,
   // two-wire bus
   input wire logic scl_pin,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // straps
   input wire logic [2:0] device_select_pins,
   input wire logic wp_pin
);
   import sfm_pkg::*;

   // ------------------------------------------------------------
   // pin synchronisers
   // ------------------------------------------------------------
   logic scl_s1, scl_s2, scl_d;
   logic sda_s1, sda_s2, sda_d;
   logic wp_s1, wp_s2;
   logic [2:0] sel_s1, sel_s2;

   // 20 samples per fastest bus clock period
   always_ff @(posedge mclk or posedge sys_rst) begin // R11
      if (sys_rst) begin
         scl_s1 <= 1'b1;
         scl_s2 <= 1'b1;
         scl_d <= 1'b1;
         sda_s1 <= 1'b1;
         sda_s2 <= 1'b1;
         sda_d <= 1'b1;
         wp_s1 <= 1'b0;
         wp_s2 <= 1'b0;
         sel_s1 <= 3'h0;
         sel_s2 <= 3'h0;
      end else begin
         scl_s1 <= scl_pin; // R9
         scl_s2 <= scl_s1;
         scl_d <= scl_s2;
         sda_s1 <= sda_in;
         sda_s2 <= sda_s1;
         sda_d <= sda_s2;
         wp_s1 <= wp_pin; // R5
         wp_s2 <= wp_s1;
         sel_s1 <= device_select_pins;
         sel_s2 <= sel_s1;
      end
   end

   // ------------------------------------------------------------
   // bus condition decode
   // ------------------------------------------------------------
   wire scl_rise = scl_s2 & ~scl_d; // R10
   wire scl_fall = ~scl_s2 & scl_d; // R10
   wire start_det = scl_s2 & scl_d & sda_d & ~sda_s2; // R12
   wire stop_det = scl_s2 & scl_d & ~sda_d & sda_s2; // R12

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   sfm_state_t state_reg, state_next;
   logic [3:0] cnt_reg;
   logic [DATA_W-1:0] shift_reg;
   logic [DATA_W-1:0] tx_reg;
   logic [HI_USED-1:0] hi_reg;
   logic [ADDR_W-1:0] addr_reg;
   logic ack_reg;
   logic sda_oe_reg;
   logic sda_out_reg;
   logic [DATA_W-1:0] rd_data;

   wire [DATA_W-1:0] rx_byte = {shift_reg[6:0], sda_s2};
   wire byte_done = scl_rise & (cnt_reg == CNT_LAST_DATA)
      & (state_reg != SFM_IDLE) & (state_reg != SFM_RDDATA);
   wire sel_match = (rx_byte[TYPE_MSB:TYPE_LSB] == DEV_TYPE)
      & (rx_byte[SEL_MSB:SEL_LSB] == sel_s2); // R1
   wire is_read = rx_byte[RW_BIT]; // R13
   wire wr_ok = (state_reg == SFM_WRDATA) & ~wp_s2; // R4
   wire [ADDR_W-1:0] addr_inc = addr_reg + 13'h0001; // R14
   wire master_nack = scl_rise & (state_reg == SFM_RDDATA)
      & (cnt_reg == CNT_ACK_SLOT) & sda_s2;
   wire ack_end = scl_fall & (cnt_reg == CNT_ACK_DONE)
      & (state_reg != SFM_IDLE);
   wire rd_load = ack_end & (state_reg == SFM_RDDATA);
   wire rd_shift = scl_fall & (state_reg == SFM_RDDATA)
      & (cnt_reg != CNT_ZERO) & (cnt_reg < CNT_ACK_SLOT);
   // a read address byte is acked too: ack_reg is still set in that slot
   wire ack_drive = scl_fall & (cnt_reg == CNT_ACK_SLOT)
      & (state_reg != SFM_IDLE) & ((state_reg != SFM_RDDATA) | ack_reg);
   wire rd_release = scl_fall & (cnt_reg == CNT_ACK_SLOT)
      & (state_reg == SFM_RDDATA) & ~ack_reg;

   sfm_wr_req_t wr_req;
   assign wr_req = '{en: byte_done & wr_ok, addr: addr_reg, data: rx_byte}; // R8

   always_comb begin
      state_next = state_reg;
      if (byte_done) begin
         unique case (state_reg)
            SFM_DEVADDR: begin
               if (!sel_match) begin
                  state_next = SFM_IDLE; // R1
               end else if (is_read) begin
                  state_next = SFM_RDDATA;
               end else begin
                  state_next = SFM_ADDR_HI;
               end
            end
            SFM_ADDR_HI: state_next = SFM_ADDR_LO;
            SFM_ADDR_LO: state_next = SFM_WRDATA;
            SFM_WRDATA: state_next = wp_s2 ? SFM_IDLE : SFM_WRDATA; // R15
            default: state_next = state_reg;
         endcase
      end else if (master_nack) begin
         state_next = SFM_IDLE; // R16
      end
   end

   // ------------------------------------------------------------
   // protocol engine
   // ------------------------------------------------------------
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= SFM_IDLE;
         cnt_reg <= CNT_ZERO;
         shift_reg <= 8'h00;
         ack_reg <= 1'b0;
      end else if (start_det) begin
         state_reg <= SFM_DEVADDR; // R12
         cnt_reg <= CNT_ZERO;
         ack_reg <= 1'b0;
      end else if (stop_det) begin
         state_reg <= SFM_IDLE; // R16
         cnt_reg <= CNT_ZERO;
         ack_reg <= 1'b0;
      end else begin
         state_reg <= state_next;
         if (scl_rise && cnt_reg < CNT_ACK_SLOT) begin
            shift_reg <= rx_byte; // R3
         end
         if (scl_rise && state_reg != SFM_IDLE) begin
            cnt_reg <= cnt_reg + 4'h1;
         end else if (ack_end) begin
            cnt_reg <= CNT_ZERO;
         end
         if (byte_done) begin
            ack_reg <= (state_reg == SFM_DEVADDR) ? sel_match
               : (state_reg == SFM_WRDATA) ? ~wp_s2 : 1'b1; // R15
         end else if (ack_end) begin
            ack_reg <= 1'b0;
         end
      end
   end

   // address latch survives bus aborts
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         addr_reg <= ADDR_FIRST;
         hi_reg <= 5'h00;
      end else if (byte_done && state_reg == SFM_ADDR_HI) begin
         hi_reg <= rx_byte[HI_USED-1:0]; // R6
      end else if (byte_done && state_reg == SFM_ADDR_LO) begin
         addr_reg <= {hi_reg, rx_byte}; // R14
      end else if ((byte_done && wr_ok) || rd_load) begin
         addr_reg <= addr_inc; // R14
      end
   end

   // open-drain driver: released or pulled low only
   always_ff @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         sda_oe_reg <= 1'b0;
         sda_out_reg <= 1'b0;
         tx_reg <= 8'h00;
      end else begin
         sda_out_reg <= 1'b0; // R2
         if (start_det || stop_det) begin
            sda_oe_reg <= 1'b0; // R16
         end else if (rd_load) begin
            tx_reg <= rd_data;
            sda_oe_reg <= ~rd_data[7]; // R3
         end else if (rd_shift) begin
            tx_reg <= {tx_reg[6:0], 1'b0};
            sda_oe_reg <= ~tx_reg[6]; // R3
         end else if (ack_drive) begin
            sda_oe_reg <= ack_reg; // R10
         end else if (ack_end || rd_release) begin
            sda_oe_reg <= 1'b0;
         end
      end
   end

   assign sda_oe = sda_oe_reg;
   assign sda_out = sda_out_reg;

   sfm_mem_array u_mem (
      .mclk(mclk),
      .wr_req(wr_req),
      .rd_addr(addr_reg),
      .rd_data(rd_data)
   );

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);

   never_high_a: assert property (sda_out == 1'b0) // R2
      else $error("data line driven high");
   oe_on_fall_a: assert property ($rose(sda_oe) |-> $past(scl_fall)) // R3
      else $error("data line pulled low away from clock fall");
   start_abort_a: assert property (start_det |=> // R12
      (state_reg == SFM_DEVADDR) && !sda_oe && cnt_reg == CNT_ZERO)
      else $error("start did not restart the frame");
   stop_idle_a: assert property (stop_det |=> ##1 // R16
      (state_reg == SFM_IDLE) && !sda_oe)
      else $error("stop did not return to idle");
   wp_no_write_a: assert property (wr_req.en |-> !wp_s2) // R4
      else $error("write issued while protected");
   wp_addr_hold_a: assert property ( // R15
      byte_done && state_reg == SFM_WRDATA && wp_s2 |=>
      $stable(addr_reg) && state_reg == SFM_IDLE ##[1:40] !sda_oe)
      else $error("protected write moved address or state");
   sel_mismatch_a: assert property ( // R1
      byte_done && state_reg == SFM_DEVADDR &&
      rx_byte[SEL_MSB:SEL_LSB] != sel_s2 |=> state_reg == SFM_IDLE)
      else $error("foreign select code accepted");
   addr_wrap_a: assert property ( // R14
      wr_req.en && addr_reg == ADDR_LAST |=> addr_reg == ADDR_FIRST)
      else $error("address did not wrap");
   write_now_a: assert property ( // R8
      byte_done && state_reg == SFM_WRDATA && !wp_s2 |->
      wr_req.en ##1 addr_reg == $past(addr_reg) + 13'h0001)
      else $error("write not completed in the transfer");

   write_cov_c: cover property (wr_req.en && !wp_s2);
   read_cov_c: cover property (rd_load);
   wp_cov_c: cover property (byte_done && state_reg == SFM_WRDATA && wp_s2);
   nack_cov_c: cover property (master_nack);
endmodule

// ===== verif/sfm_bus_master.sv
module sfm_bus_master (
   // clock
   input wire logic mclk,
   // two-wire bus
   input wire logic sda_line,
   output logic scl,
   output logic sda_drv
);
   timeunit 1ns;
   timeprecision 1ns;

   // ------------------------------------------------------------
   // bus idles high; clock stands still outside frames
   // ------------------------------------------------------------
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
   end

   task automatic wait_clk(input int n);
      repeat (n) @(negedge mclk);
   endtask

   // one slot of 400 ns: data set mid low phase, sampled at end of high
   task automatic bit_io(input logic b, output logic r);
      wait_clk(2);
      sda_drv = b;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      r = sda_line;
      scl = 1'b0;
   endtask

   task automatic start_cond;
      wait_clk(2);
      sda_drv = 1'b1;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      sda_drv = 1'b0;
      wait_clk(4);
      scl = 1'b0;
   endtask

   task automatic stop_cond;
      wait_clk(2);
      sda_drv = 1'b0;
      wait_clk(2);
      scl = 1'b1;
      wait_clk(4);
      sda_drv = 1'b1;
      wait_clk(4);
   endtask

   task automatic put_byte(input logic [7:0] d, output logic ack);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], r);
      end
      bit_io(1'b1, r);
      ack = ~r;
   endtask

   task automatic get_byte(input logic more, output logic [7:0] d);
      logic r;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, d[i]);
      end
      bit_io(~more, r);
   endtask
endmodule

// ===== verif/sfm_two_wire_slave_bench.sv
module sfm_two_wire_slave_bench;
   timeunit 1ns;
   timeprecision 1ns;
   import sfm_pkg::*;

   logic mclk = 1'b0;
   logic sys_rst = 1'b1;
   logic [2:0] sel = 3'h0;
   logic wp = 1'b0;
   logic scl, m_sda, sda_out, sda_oe, oe_q, ack;
   logic [7:0] rd;
   wire logic sda_line;
   int n_mismatch = 0;
   int checks = 0;

   always #25 mclk = ~mclk;
   // open-drain wire with pull-up
   assign sda_line = m_sda & ~(sda_oe & ~sda_out);

   sfm_two_wire_slave dut_u (.mclk(mclk), .sys_rst(sys_rst),
      .scl_pin(scl), .sda_in(sda_line), .sda_out(sda_out),
      .sda_oe(sda_oe), .device_select_pins(sel), .wp_pin(wp));
   sfm_bus_master mst_u (.mclk(mclk), .sda_line(sda_line), .scl(scl),
      .sda_drv(m_sda));

   // ------------------------------------------------------------
   // checking and closing
   // ------------------------------------------------------------
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic print_verdict;
      $display("Counts: checks=%0d mismatches=%0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // driven level is never high; answer changes only while clock is low
   always @(posedge mclk) begin
      oe_q <= sda_oe;
      if (sda_oe === 1'b1 && sda_out !== 1'b0) begin
         chk({7'h0, sda_out}, 8'h00);
      end
      if (!sys_rst && sda_oe !== oe_q && scl !== 1'b0) begin
         chk({7'h0, scl}, 8'h00);
      end
   end

   // ------------------------------------------------------------
   // transfer helpers
   // ------------------------------------------------------------
   task automatic set_addr(input logic [12:0] a);
      mst_u.start_cond();
      mst_u.put_byte({DEV_TYPE, sel, 1'b0}, ack);
      chk({7'h0, ack}, 8'h01);
      mst_u.put_byte({3'h0, a[12:8]}, ack);
      chk({7'h0, ack}, 8'h01);
      mst_u.put_byte(a[7:0], ack);
      chk({7'h0, ack}, 8'h01);
   endtask

   task automatic wr(input logic [12:0] a, input logic [7:0] d0,
                     input logic [7:0] d1, input int n);
      set_addr(a);
      mst_u.put_byte(d0, ack);
      chk({7'h0, ack}, 8'h01);
      if (n > 1) begin
         mst_u.put_byte(d1, ack);
         chk({7'h0, ack}, 8'h01);
      end
      mst_u.stop_cond();
   endtask

   // current-address read of one or two bytes
   task automatic rd_cur(input int n, input logic [7:0] e0,
                         input logic [7:0] e1);
      mst_u.start_cond();
      mst_u.put_byte({DEV_TYPE, sel, 1'b1}, ack);
      chk({7'h0, ack}, 8'h01);
      mst_u.get_byte(n > 1, rd);
      chk(rd, e0);
      if (n > 1) begin
         mst_u.get_byte(1'b0, rd);
         chk(rd, e1);
      end
      mst_u.stop_cond();
   endtask

   // ------------------------------------------------------------
   // scenarios
   // ------------------------------------------------------------
   task automatic t_basic;
      wr(13'h0123, 8'hA5, 8'h3C, 2);
      set_addr(13'h0123);
      rd_cur(2, 8'hA5, 8'h3C);
   endtask

   task automatic t_wrap;
      wr(ADDR_LAST, 8'h11, 8'h22, 2);
      set_addr(ADDR_LAST);
      rd_cur(2, 8'h11, 8'h22);
   endtask

   task automatic t_select;
      @(negedge mclk);
      sel = 3'h5;
      for (int s = 0; s < 8; s++) begin
         mst_u.start_cond();
         mst_u.put_byte({DEV_TYPE, s[2:0], 1'b0}, ack);
         chk({7'h0, ack}, {7'h0, s[2:0] == 3'h5});
         mst_u.stop_cond();
      end
      mst_u.start_cond();
      mst_u.put_byte({DEV_TYPE ^ 4'h1, sel, 1'b0}, ack);
      chk({7'h0, ack}, 8'h00);
      mst_u.stop_cond();
      @(negedge mclk);
      sel = 3'h0;
   endtask

   task automatic t_protect;
      wr(13'h0040, 8'h5A, 8'h77, 2);
      @(negedge mclk);
      wp = 1'b1;
      set_addr(13'h0041);
      mst_u.put_byte(8'hEE, ack);
      chk({7'h0, ack}, 8'h00);
      mst_u.stop_cond();
      @(negedge mclk);
      wp = 1'b0;
      rd_cur(1, 8'h77, 8'h00);
   endtask

   task automatic t_abort;
      logic r;
      wr(13'h0200, 8'h99, 8'h00, 1);
      for (int k = 0; k < 2; k++) begin
         set_addr(13'h0200);
         for (int i = 0; i < 4; i++) begin
            mst_u.bit_io(1'b0, r);
         end
         if (k == 0) begin
            mst_u.start_cond();
         end
         mst_u.stop_cond();
         rd_cur(1, 8'h99, 8'h00);
      end
   endtask

   initial begin
      #2ms;
      n_mismatch++;
      print_verdict();
   end

   initial begin
      repeat (10) @(negedge mclk);
      sys_rst = 1'b0;
      repeat (4) @(negedge mclk);
      chk({7'h0, sda_oe}, 8'h00);
      t_basic();
      t_wrap();
      t_select();
      t_protect();
      t_abort();
      print_verdict();
   end
endmodule
